// >>> flash_core_model.sv
// far-side model: program flash array answering word reads, free-running rc oscillator
`timescale 1ns/1ps
module flash_core_model #(
    parameter int RC_HALF_NS = 50
) (
    input wire logic clk_in,
    input wire logic flash_read_in,
    input wire logic [14:0] word_addr_in,
    output logic [15:0] rdata_out,
    output logic rc_osc_out
);
    logic [15:0] word_r = 16'h0000;

    assign rdata_out = word_r;

    initial begin
        rc_osc_out = 1'b0;
        #7;
        forever #(RC_HALF_NS) rc_osc_out = ~rc_osc_out;
    end
    // word stands the cycle after the request; otherwise the bus toggles so stale data never passes
    always @(posedge clk_in) begin
        if (flash_read_in === 1'b1) begin
            word_r <= {word_addr_in[7:0] ^ 8'hA5, word_addr_in[7:0]};
        end else begin
            word_r <= ~word_r;
        end
    end
endmodule : flash_core_model

// >>> flash_selfprog_addr_fuse_read.sv
// store/load sequencer: pointer decode, fuse and lock reads, timed erase/write
`timescale 1ns/1ps
module flash_selfprog_addr_fuse_read
    import flash_selfprog_pkg::*;
#(
    parameter int WORD_SEL_BITS = WORD_SEL_BITS_DEFAULT,
    parameter int PROG_TICKS = PROG_TICKS_DEFAULT
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic power_on_reset_in,
    input wire logic ctrl_write_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic store_exec_in,
    input wire logic [15:0] store_data_in,
    input wire logic load_exec_in,
    input wire logic [PTR_W-1:0] pointer_in,
    input wire logic eeprom_write_busy_in,
    input wire logic rc_osc_in,
    input wire nv_config_t nv_programmed_in,
    input wire logic [15:0] flash_rdata_in,
    output logic [7:0] program_store_ctrl_status_out,
    output logic [7:0] load_data_out,
    output logic load_valid_out,
    output logic flash_read_out,
    output logic [PTR_W-2:0] flash_word_addr_out,
    output logic [PTR_W-2-WORD_SEL_BITS:0] page_addr_out,
    output logic [WORD_SEL_BITS-1:0] word_sel_out,
    output logic [15:0] buffer_data_out,
    output logic buffer_load_out,
    output logic buffer_clear_out,
    output logic page_erase_out,
    output logic page_write_out,
    output logic lock_write_out,
    output logic ctrl_refused_out,
    output logic cpu_halt_out
);
    localparam int PAGE_W = PTR_W - 1 - WORD_SEL_BITS;
    generate
        if (WORD_SEL_BITS < 1 || WORD_SEL_BITS > PTR_W - 2) begin : g_bad_ws
            $error("WORD_SEL_BITS out of range");
        end
        if (PROG_TICKS < 1 || PROG_TICKS > PROG_TICKS_MAX) begin : g_bad_ticks
            $error("PROG_TICKS outside the erase/write window");
        end
        if (RC_KHZ_DEFAULT * 5 > CLK_KHZ) begin : g_bad_rc
            $error("oscillator too fast for the synchroniser");
        end
    endgenerate
    seq_state_t state_r;
    seq_state_t state_nxt;
    ctrl_bits_t ctrl_r;
    ctrl_bits_t ctrl_nxt;
    logic [2:0] rem_r;
    logic [2:0] rem_nxt;
    logic osc_level;
    logic osc_prev_r;
    logic op_done;
    logic rd1_r;
    logic fuse1_r;
    logic sel1_r;
    logic [7:0] fbyte1_r;
    logic rd2_r;
    logic fuse2_r;
    logic sel2_r;
    logic [7:0] fbyte2_r;
    // oscillator edges arrive from outside the clock domain
    pin_sync3 u_osc_sync (
        .clk_in(clk_in),
        .clear_in(power_on_reset_in),
        .async_in(rc_osc_in),
        .level_out(osc_level)
    );
    wire osc_tick = osc_level && !osc_prev_r;
    // command decode
    wire [4:0] wcmd = ctrl_wdata_in[4:0];
    wire cmd_ok = (wcmd == CMD_BUF_LOAD) || (wcmd == CMD_ERASE) || (wcmd == CMD_WRITE)
                  || (wcmd == CMD_LOCK_FUSE) || (wcmd == CMD_RWW_REEN);
    wire wr_go = ctrl_write_in && cmd_ok && !eeprom_write_busy_in && (state_r != ST_PROG);
    wire wr_refused = ctrl_write_in && cmd_ok && !wr_go;
    wire [4:0] cur = ctrl_r;
    wire armed = (state_r == ST_ARMED) && (rem_r != WINDOW_CNT_ZERO);
    wire is_erase = cur == CMD_ERASE;
    wire is_write = cur == CMD_WRITE;
    wire is_lock = cur == CMD_LOCK_FUSE;
    wire is_buf = cur == CMD_BUF_LOAD;
    wire is_reen = cur == CMD_RWW_REEN;
    wire store_go = store_exec_in && armed && !eeprom_write_busy_in;
    wire store_refused = store_exec_in && armed && eeprom_write_busy_in;
    wire op_go = store_go && (is_erase || is_write || is_lock);
    wire fuse_sel = armed && ctrl_r.lock_fuse_read_select && ctrl_r.store_enable;
    wire fuse_go = load_exec_in && fuse_sel && !eeprom_write_busy_in;
    wire fuse_refused = load_exec_in && fuse_sel && eeprom_write_busy_in;
    wire win_last = armed && (rem_r == 3'h1);
    wire arm_clear = (state_r == ST_ARMED) && !op_go && !wr_go
                     && (store_go || fuse_go || win_last);
    // pointer fields: word within page, then page; bit zero only for loads
    wire [PAGE_W-1:0] ptr_page = pointer_in[PTR_W-1:WORD_SEL_BITS+1];
    wire [WORD_SEL_BITS-1:0] ptr_word_sel = pointer_in[WORD_SEL_BITS:1];
    wire [PTR_W-2:0] ptr_word = pointer_in[PTR_W-1:1];
    wire ptr_b0 = pointer_in[0];
    // inversion turns programmed flags into read-as-zero bits
    wire [7:0] fuse_pick =
        (pointer_in == PTR_FUSE_HIGH) ? ~nv_programmed_in.fuse_high_byte :
        (pointer_in == PTR_FUSE_EXT) ? ~nv_programmed_in.fuse_extended_byte :
        ptr_b0 ? ~nv_programmed_in.lock_bits :
        ~nv_programmed_in.fuse_low_byte;
    wire [7:0] rdata_hi = flash_rdata_in[15:8];
    wire [7:0] rdata_lo = flash_rdata_in[7:0];
    wire [7:0] byte_pick = sel2_r ? rdata_hi : rdata_lo;
    wire [7:0] load_pick = fuse2_r ? fbyte2_r : byte_pick;
    wire [7:0] status_nxt = {1'b0, 1'b0, 1'b0, ctrl_r};
    wire hold_prog = reset_in && (state_r == ST_PROG);

    always_comb begin
        state_nxt = state_r;
        ctrl_nxt = ctrl_r;
        rem_nxt = WINDOW_CNT_ZERO;
        case (state_r)
            ST_IDLE: begin
                if (wr_go) begin
                    state_nxt = ST_ARMED;
                    ctrl_nxt = wcmd;
                    rem_nxt = (wcmd == CMD_LOCK_FUSE) ? 3'(LOAD_WINDOW_CYC) : 3'(STORE_WINDOW_CYC);
                end
            end
            ST_ARMED: begin
                if (wr_go) begin
                    ctrl_nxt = wcmd;
                    rem_nxt = (wcmd == CMD_LOCK_FUSE) ? 3'(LOAD_WINDOW_CYC) : 3'(STORE_WINDOW_CYC);
                end else if (op_go) begin
                    state_nxt = ST_PROG;
                end else if (arm_clear) begin
                    state_nxt = ST_IDLE;
                    ctrl_nxt = CTRL_RESET;
                end else begin
                    rem_nxt = rem_r - 3'h1;
                end
            end
            ST_PROG: begin
                if (op_done) begin
                    state_nxt = ST_IDLE;
                    ctrl_nxt = CTRL_RESET;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ctrl_nxt = CTRL_RESET;
            end
        endcase
    end

    // a system reset leaves a running operation and its bits alone
    always_ff @(posedge clk_in) begin
        if (power_on_reset_in || (reset_in && !hold_prog)) begin
            state_r <= ST_IDLE;
            ctrl_r <= CTRL_RESET;
            rem_r <= WINDOW_CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            rem_r <= rem_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (power_on_reset_in) begin
            osc_prev_r <= 1'b0;
            program_store_ctrl_status_out <= STATUS_RESET;
        end else begin
            osc_prev_r <= osc_level;
            program_store_ctrl_status_out <= status_nxt;
        end
    end

    // command strobes, one cycle each
    always_ff @(posedge clk_in) begin
        if (power_on_reset_in || reset_in) begin
            buffer_load_out <= 1'b0;
            buffer_clear_out <= 1'b0;
            page_erase_out <= 1'b0;
            page_write_out <= 1'b0;
            lock_write_out <= 1'b0;
            ctrl_refused_out <= 1'b0;
        end else begin
            buffer_load_out <= store_go && is_buf;
            buffer_clear_out <= store_go && is_reen;
            page_erase_out <= store_go && is_erase;
            page_write_out <= store_go && is_write;
            lock_write_out <= store_go && is_lock;
            ctrl_refused_out <= wr_refused || store_refused || fuse_refused;
        end
    end

    // address and data captured with each store
    always_ff @(posedge clk_in) begin
        if (power_on_reset_in || reset_in) begin
            page_addr_out <= '0;
            word_sel_out <= '0;
            buffer_data_out <= 16'h0000;
        end else if (store_go) begin
            page_addr_out <= ptr_page;
            word_sel_out <= ptr_word_sel;
            buffer_data_out <= store_data_in;
        end
    end

    // load path: three cycles for both flash bytes and fuse bytes
    always_ff @(posedge clk_in) begin
        if (power_on_reset_in || reset_in) begin
            rd1_r <= 1'b0;
            fuse1_r <= 1'b0;
            sel1_r <= 1'b0;
            fbyte1_r <= 8'h00;
            flash_read_out <= 1'b0;
            flash_word_addr_out <= '0;
        end else begin
            rd1_r <= load_exec_in;
            fuse1_r <= fuse_go;
            sel1_r <= ptr_b0;
            fbyte1_r <= fuse_pick;
            flash_read_out <= load_exec_in && !fuse_go;
            flash_word_addr_out <= load_exec_in ? ptr_word : flash_word_addr_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (power_on_reset_in || reset_in) begin
            rd2_r <= 1'b0;
            fuse2_r <= 1'b0;
            sel2_r <= 1'b0;
            fbyte2_r <= 8'h00;
            load_valid_out <= 1'b0;
            load_data_out <= 8'h00;
        end else begin
            rd2_r <= rd1_r;
            fuse2_r <= fuse1_r;
            sel2_r <= sel1_r;
            fbyte2_r <= fbyte1_r;
            load_valid_out <= rd2_r;
            load_data_out <= rd2_r ? load_pick : load_data_out;
        end
    end

    // busy also halts the cpu
    prog_timer #(
        .TICKS(PROG_TICKS)
    ) u_timer (
        .clk_in(clk_in),
        .clear_in(power_on_reset_in),
        .start_in(op_go),
        .tick_in(osc_tick),
        .busy_out(cpu_halt_out),
        .done_out(op_done)
    );

    logic [31:0] ticks_seen_r;
    wire [7:0] lock_prog = nv_programmed_in.lock_bits;
    wire [7:0] low_prog = nv_programmed_in.fuse_low_byte;
    wire [7:0] high_prog = nv_programmed_in.fuse_high_byte;
    wire [7:0] ext_prog = nv_programmed_in.fuse_extended_byte;

    always_ff @(posedge clk_in) begin
        if (power_on_reset_in || op_go) begin
            ticks_seen_r <= 32'h0;
        end else if (cpu_halt_out && osc_tick) begin
            ticks_seen_r <= ticks_seen_r + 32'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (power_on_reset_in || reset_in);

    store_page_a: assert property (page_erase_out || page_write_out |->
        page_addr_out == $past(ptr_page)) else $error("page address not from pointer");
    word_field_a: assert property (buffer_load_out |->
        word_sel_out == $past(ptr_word_sel)) else $error("word field wrong");
    flash_byte_a: assert property ((load_exec_in && !fuse_sel) |->
        ##3 (load_valid_out && load_data_out ==
        ($past(ptr_b0, 3) ? $past(rdata_hi) : $past(rdata_lo))))
        else $error("ordinary byte read wrong");
    eeprom_block_a: assert property (eeprom_write_busy_in |=>
        !(page_erase_out || page_write_out || lock_write_out || buffer_load_out))
        else $error("programming during eeprom write");
    fuse_block_a: assert property ((load_exec_in && fuse_sel && eeprom_write_busy_in) |->
        ##3 (load_valid_out && load_data_out ==
        ($past(ptr_b0, 3) ? $past(rdata_hi) : $past(rdata_lo))))
        else $error("fuse read during eeprom write");
    lock_read_a: assert property ((fuse_go && pointer_in == PTR_LOCK) |->
        ##3 (load_valid_out && load_data_out == ~$past(lock_prog, 3)))
        else $error("lock bits read wrong");
    low_fuse_a: assert property ((fuse_go && pointer_in == PTR_FUSE_LOW) |->
        ##3 (load_data_out == ~$past(low_prog, 3))) else $error("low fuse read wrong");
    high_fuse_a: assert property ((fuse_go && pointer_in == PTR_FUSE_HIGH) |->
        ##3 (load_data_out == ~$past(high_prog, 3))) else $error("high fuse read wrong");
    ext_fuse_a: assert property ((fuse_go && pointer_in == PTR_FUSE_EXT) |->
        ##3 (load_data_out == ~$past(ext_prog, 3))) else $error("extended fuse read wrong");
    load_window_a: assert property ((wr_go && wcmd == CMD_LOCK_FUSE) ##1
        (!store_exec_in && !load_exec_in && !ctrl_write_in)[*3] |=>
        (state_r == ST_IDLE && ctrl_r == CTRL_RESET)) else $error("read window not closed");
    store_window_a: assert property ((wr_go && wcmd == CMD_BUF_LOAD) ##1
        (!store_exec_in && !ctrl_write_in)[*4] |=> state_r == ST_IDLE)
        else $error("store window not closed");
    erase_halt_a: assert property (page_erase_out |-> cpu_halt_out &&
        program_store_ctrl_status_out[0] == 1'b1 ##1 cpu_halt_out)
        else $error("cpu not halted at erase");
    prog_time_a: assert property ($fell(cpu_halt_out) |->
        (op_done && ticks_seen_r == 32'(PROG_TICKS))) else $error("operation length wrong");
    enable_hold_a: assert property (cpu_halt_out && !op_done |->
        ctrl_r.store_enable) else $error("store enable dropped while busy");
    rww_zero_a: assert property (program_store_ctrl_status_out[RWW_BUSY_POS] == 1'b0)
        else $error("rww busy bit set");
    reset_keep_a: assert property (@(posedge clk_in) disable iff (power_on_reset_in)
        (state_r == ST_PROG && reset_in && !op_done) |=> state_r == ST_PROG)
        else $error("reset aborted an operation");

endmodule : flash_selfprog_addr_fuse_read

// >>> flash_selfprog_pkg.sv
// shared constants and types for the flash self-programming sequencer
package flash_selfprog_pkg;

    localparam int PTR_W = 16;
    localparam int WORD_SEL_BITS_DEFAULT = 5;
    localparam int STORE_WINDOW_CYC = 4;
    localparam int LOAD_WINDOW_CYC = 3;
    localparam logic [2:0] WINDOW_CNT_ZERO = 3'h0;

    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

    localparam int RWW_BUSY_POS = 6;
    localparam logic [4:0] CMD_BUF_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK_FUSE = 5'h09;
    localparam logic [4:0] CMD_RWW_REEN = 5'h11;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    localparam longint CLK_KHZ = 40_000;
    localparam longint RC_KHZ_DEFAULT = 8_000;
    localparam longint PROG_MIN_NS = 3_200_000;
    localparam longint PROG_MAX_NS = 3_400_000;
    // one tick beyond the rounded-up minimum: the first tick can land anywhere
    localparam int PROG_TICKS_DEFAULT =
        int'((PROG_MIN_NS * RC_KHZ_DEFAULT + 64'd999_999) / 64'd1_000_000) + 1;
    localparam int PROG_TICKS_MAX = int'((PROG_MAX_NS * RC_KHZ_DEFAULT) / 64'd1_000_000);

    typedef struct packed {
        logic rww_read_reenable;
        logic lock_fuse_read_select;
        logic page_write_bit;
        logic page_erase_bit;
        logic store_enable;
    } ctrl_bits_t;

    // each bit high means that bit is programmed
    typedef struct packed {
        logic [7:0] lock_bits;
        logic [7:0] fuse_extended_byte;
        logic [7:0] fuse_high_byte;
        logic [7:0] fuse_low_byte;
    } nv_config_t;

    typedef enum {ST_IDLE, ST_ARMED, ST_PROG} seq_state_t;

endpackage : flash_selfprog_pkg

// >>> pin_sync3.sv
// three-stage synchroniser, level accepted once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
    input wire logic clk_in,
    input wire logic clear_in,
    input wire logic async_in,
    output logic level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_in) begin
        if (clear_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule : pin_sync3

// >>> prog_timer.sv
// oscillator tick counter timing one erase or write operation
`timescale 1ns/1ps
module prog_timer #(
    parameter int TICKS = 16,
    parameter int CNT_W = $clog2(TICKS + 1)
) (
    input wire logic clk_in,
    input wire logic clear_in,
    input wire logic start_in,
    input wire logic tick_in,
    output logic busy_out,
    output logic done_out
);
    logic [CNT_W-1:0] cnt_r;
    wire last_tick = busy_out && tick_in && (cnt_r == CNT_W'(TICKS - 1));

    generate
        if (TICKS < 1) begin : g_bad
            $error("prog_timer needs at least one tick");
        end
    endgenerate

    // only power-on clears it, so an operation outlives a system reset
    always_ff @(posedge clk_in) begin
        if (clear_in) begin
            cnt_r <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= last_tick;
            if (start_in && !busy_out) begin
                busy_out <= 1'b1;
                cnt_r <= '0;
            end else if (last_tick) begin
                busy_out <= 1'b0;
            end else if (busy_out && tick_in) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : prog_timer

// >>> test_flash_selfprog_addr_fuse_read.sv
// self-checking bench for the store/load sequencer
`timescale 1ns/1ps
module test_flash_selfprog_addr_fuse_read
    import flash_selfprog_pkg::*;
;
    localparam int TICKS = 6;
    logic clk_in = 1'b0, reset_in = 1'b1, power_on_reset_in = 1'b1;
    logic ctrl_write_in = 1'b0, store_exec_in = 1'b0, load_exec_in = 1'b0;
    logic [7:0] ctrl_wdata_in = 8'h00;
    logic [15:0] store_data_in = 16'h0000, pointer_in = 16'h0000, flash_rdata_in;
    logic eeprom_write_busy_in = 1'b0, rc_osc_in;
    nv_config_t nv = '{8'h3C, 8'h06, 8'hD9, 8'h62};
    logic [7:0] status_out, load_data_out;
    logic load_valid_out, flash_read_out, buffer_load_out, page_erase_out, page_write_out;
    logic ctrl_refused_out, cpu_halt_out, buffer_clear_out, lock_write_out;
    logic [14:0] flash_word_addr_out;
    logic [9:0] page_addr_out;
    logic [4:0] word_sel_out;
    logic [15:0] buffer_data_out;
    int n_mismatch = 0, n_checks = 0;

    always #12.5 clk_in = ~clk_in;

    flash_selfprog_addr_fuse_read #(.WORD_SEL_BITS(5), .PROG_TICKS(TICKS))
        flash_selfprog_addr_fuse_read_i (
        .clk_in(clk_in), .reset_in(reset_in), .power_on_reset_in(power_on_reset_in),
        .ctrl_write_in(ctrl_write_in), .ctrl_wdata_in(ctrl_wdata_in),
        .store_exec_in(store_exec_in), .store_data_in(store_data_in),
        .load_exec_in(load_exec_in), .pointer_in(pointer_in),
        .eeprom_write_busy_in(eeprom_write_busy_in), .rc_osc_in(rc_osc_in),
        .nv_programmed_in(nv), .flash_rdata_in(flash_rdata_in),
        .program_store_ctrl_status_out(status_out), .load_data_out(load_data_out),
        .load_valid_out(load_valid_out), .flash_read_out(flash_read_out),
        .flash_word_addr_out(flash_word_addr_out), .page_addr_out(page_addr_out),
        .word_sel_out(word_sel_out), .buffer_data_out(buffer_data_out),
        .buffer_load_out(buffer_load_out), .buffer_clear_out(buffer_clear_out),
        .page_erase_out(page_erase_out), .page_write_out(page_write_out),
        .lock_write_out(lock_write_out), .ctrl_refused_out(ctrl_refused_out),
        .cpu_halt_out(cpu_halt_out)
    );

    flash_core_model flash_core_model_i (
        .clk_in(clk_in), .flash_read_in(flash_read_out), .word_addr_in(flash_word_addr_out),
        .rdata_out(flash_rdata_in), .rc_osc_out(rc_osc_in)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // inputs always change 2 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : cyc

    function automatic logic [7:0] exp_byte(input logic [15:0] p);
        logic [7:0] w;
        w = p[8:1];
        return p[0] ? (w ^ 8'hA5) : w;
    endfunction : exp_byte

    task automatic ctrl(input logic [7:0] v);
        ctrl_wdata_in = v;
        ctrl_write_in = 1'b1;
        cyc(1);
        ctrl_write_in = 1'b0;
    endtask : ctrl

    task automatic store(input logic [15:0] p, input logic [15:0] d);
        pointer_in = p;
        store_data_in = d;
        store_exec_in = 1'b1;
        cyc(1);
        store_exec_in = 1'b0;
    endtask : store

    task automatic load(input logic [15:0] p, output logic [7:0] d);
        int k;
        pointer_in = p;
        load_exec_in = 1'b1;
        cyc(1);
        load_exec_in = 1'b0;
        k = 0;
        while (load_valid_out !== 1'b1 && k < 6) begin
            cyc(1);
            k++;
        end
        chk(16'(k), 16'h0002);
        d = load_data_out;
    endtask : load

    task automatic wait_halt(output int n);
        n = 0;
        while (cpu_halt_out === 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
    endtask : wait_halt

    task automatic t_fuse();
        logic [7:0] d;
        logic [7:0] exp [4];
        exp = '{~nv.fuse_low_byte, ~nv.lock_bits, ~nv.fuse_extended_byte, ~nv.fuse_high_byte};
        for (int i = 0; i < 4; i++) begin
            ctrl(8'h09);
            load(16'(i), d);
            chk(16'(d), 16'(exp[i]));
            chk(16'(status_out), 16'h0000);
        end
        $display("test fuse_reads done");
    endtask : t_fuse

    task automatic t_plain();
        logic [7:0] d;
        load(16'h0247, d);
        chk(16'(d), 16'(exp_byte(16'h0247)));
        load(16'h0246, d);
        chk(16'(d), 16'(exp_byte(16'h0246)));
        // window left to lapse: lock pointer must read plain flash
        ctrl(8'h09);
        cyc(4);
        load(16'h0001, d);
        chk(16'(d), 16'(exp_byte(16'h0001)));
        $display("test plain_loads done");
    endtask : t_plain

    task automatic t_store_window();
        logic [15:0] p;
        p = 16'hABCD;
        for (int g = 3; g < 5; g++) begin
            ctrl(8'h01);
            cyc(g);
            store(p, 16'h1234 + 16'(g));
            chk(16'(buffer_load_out), 16'(g == 3));
        end
        chk(16'(word_sel_out), 16'(p[5:1]));
        chk(buffer_data_out, 16'h1237);
        $display("test store_window done");
    endtask : t_store_window

    task automatic t_erase();
        int n;
        logic [15:0] p;
        p = 16'hC3C0;
        ctrl(8'h03);
        store(p, 16'h0000);
        chk(16'(page_erase_out), 16'h0001);
        chk(16'(cpu_halt_out), 16'h0001);
        chk(16'(page_addr_out), 16'(p[15:6]));
        ctrl(8'h05);
        chk(16'(ctrl_refused_out), 16'h0001);
        chk(16'(status_out), 16'h0003);
        wait_halt(n);
        chk(16'(n >= (TICKS - 2) * 4 && n <= (TICKS + 2) * 4), 16'h0001);
        cyc(2);
        chk(16'(status_out), 16'h0000);
        $display("test erase_timing done");
    endtask : t_erase

    task automatic t_busy();
        logic [7:0] d;
        eeprom_write_busy_in = 1'b1;
        ctrl(8'h03);
        chk(16'(ctrl_refused_out), 16'h0001);
        store(16'h0040, 16'h0000);
        chk(16'(page_erase_out), 16'h0000);
        chk(16'(cpu_halt_out), 16'h0000);
        eeprom_write_busy_in = 1'b0;
        ctrl(8'h09);
        eeprom_write_busy_in = 1'b1;
        load(16'h0000, d);
        chk(16'(d), 16'(exp_byte(16'h0000)));
        eeprom_write_busy_in = 1'b0;
        $display("test eeprom_busy done");
    endtask : t_busy

    task automatic t_reset_mid_write();
        int n;
        ctrl(8'h05);
        store(16'hC3C0, 16'h0000);
        chk(16'(page_write_out), 16'h0001);
        chk(16'(page_addr_out), 16'h030F);
        reset_in = 1'b1;
        cyc(2);
        reset_in = 1'b0;
        chk(16'(cpu_halt_out), 16'h0001);
        wait_halt(n);
        chk(16'(n > 4 && n < 400), 16'h0001);
        $display("test reset_mid_write done");
    endtask : t_reset_mid_write

    task automatic t_special();
        int n;
        ctrl(8'h11);
        store(16'h0000, 16'h0000);
        chk(16'(buffer_clear_out), 16'h0001);
        ctrl(8'h09);
        store(16'h0001, 16'h0000);
        chk(16'(lock_write_out), 16'h0001);
        chk(16'(cpu_halt_out), 16'h0001);
        chk(16'(status_out), 16'h0009);
        wait_halt(n);
        chk(16'(n >= (TICKS - 2) * 4 && n <= (TICKS + 2) * 4), 16'h0001);
        cyc(2);
        $display("test special_stores done");
    endtask : t_special

    // far above the hundred-odd cycles the tests need
    initial begin
        #(25 * 20000);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        cyc(2);
        reset_in = 1'b0;
        power_on_reset_in = 1'b0;
        cyc(1);
        t_fuse();
        t_plain();
        t_store_window();
        t_special();
        t_erase();
        t_busy();
        t_reset_mid_write();
        wrap_up();
    end
endmodule : test_flash_selfprog_addr_fuse_read
